// ---- rtl/ccd_consts.svh ----
// Constants for the clear, call and decrement execution block.
// Assumes it is included by bare name after the include path is set to rtl/.
`ifndef CCD_CONSTS_SVH
`define CCD_CONSTS_SVH

// Widths and depths
`define PC_W          13
`define DATA_W        8
`define FADDR_W       7
`define INSTR_W       14
`define FILE_DEPTH    128
`define STACK_DEPTH   8
`define STACK_PTR_W   3
`define PAGE_W        5
`define CALL_K_W      11
`define DOG_CNT_W     8
`define DOG_PRE_W     8

// Watchdog prescaler terminal count, in instruction cycles
`define DOG_PRE_LIMIT 8'h80

// Instruction word field positions
`define OP_HI         13
`define OP_LO         8
`define CALL_PFX_LO   11
`define DEST_BIT      7
`define PAGE_HI       4
`define PAGE_LO       3

// Opcode encodings
`define OP_CALL_PFX   3'h4
`define OP_INVERT     6'h11
`define OP_DEC        6'h12
`define OP_DEC_SKIP   6'h13
`define OP_ZERO       6'h14
`define OP_DOG_CLEAR  14'h0015

// Reset and constant values
`define PC_RESET      13'h0000
`define ZERO_BYTE     8'h00
`define ONE_BYTE      8'h01
`define PC_ONE        13'h0001
`define PC_TWO        13'h0002

`endif

// ---- rtl/ccd_pkg.sv ----
// Types shared by the clear, call and decrement execution block.
// Assumes nothing beyond a SystemVerilog compiler.
package ccd_pkg;

  // Core sequencing state
  typedef enum logic [0:0] {
    ST_EXEC  = 1'b0,
    ST_FLUSH = 1'b1
  } core_state_t;

  // Decoded instruction class
  typedef enum logic [2:0] {
    OPC_NONE     = 3'b000,
    OPC_DOG      = 3'b001,
    OPC_CALL     = 3'b010,
    OPC_INVERT   = 3'b011,
    OPC_ZERO_F   = 3'b100,
    OPC_ZERO_A   = 3'b101,
    OPC_DEC      = 3'b110,
    OPC_DEC_SKIP = 3'b111
  } op_class_t;

endpackage : ccd_pkg

// ---- rtl/ccd_return_stack.sv ----
// Circular hardware return stack holding program counter values.
// Assumes one push per cycle at most; overflow wraps and overwrites the oldest.
`timescale 1ns/10ps
`default_nettype none
`include "ccd_consts.svh"

module ccd_return_stack
  import ccd_pkg::*;
(
  input  wire logic              clk_i,
  input  wire logic              rstn_i,
  input  wire logic              push_i,
  input  wire logic [`PC_W-1:0]  data_i,
  output logic      [`PC_W-1:0]  top_o
);

  logic [`PC_W-1:0]        entry_mem [`STACK_DEPTH];
  logic [`STACK_PTR_W-1:0] ptr_reg;
  logic [`PC_W-1:0]        top_reg;

  // Entries are storage only, so they carry no reset
  always_ff @(posedge clk_i) begin
    if (push_i) begin
      entry_mem[ptr_reg] <= data_i;
    end
  end

  // Pointer wraps silently; there is no overflow indication by design
  always_ff @(posedge clk_i) begin
    if (!rstn_i) begin
      ptr_reg <= '0;
      top_reg <= `PC_RESET;
    end else if (push_i) begin
      ptr_reg <= ptr_reg + 1'b1;
      top_reg <= data_i;
    end
  end

  assign top_o = top_reg;

endmodule : ccd_return_stack
`default_nettype wire

// ---- rtl/ccd_watchdog.sv ----
// Watchdog counter with its prescaler, counting one step per instruction cycle.
// Assumes the clear input is a one-cycle pulse from the instruction decoder.
`timescale 1ns/10ps
`default_nettype none
`include "ccd_consts.svh"

module ccd_watchdog
  import ccd_pkg::*;
#(
  parameter logic [`DOG_PRE_W-1:0] PRE_LIMIT = `DOG_PRE_LIMIT
)
(
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  clear_i,
  output logic      [`DOG_CNT_W-1:0] count_o,
  output logic      [`DOG_PRE_W-1:0] prescale_o,
  output logic                       expire_o
);

  logic [`DOG_PRE_W-1:0] pre_reg;
  logic [`DOG_CNT_W-1:0] cnt_reg;
  logic                  pre_wrap;
  logic                  expire_reg;

  assign pre_wrap = (pre_reg == PRE_LIMIT - 1'b1);

  // Clear beats counting, but an expiry registered the cycle before can still coincide with a clear
  always_ff @(posedge clk_i) begin
    if (!rstn_i || clear_i) begin
      pre_reg    <= '0;
      cnt_reg    <= '0;
      expire_reg <= 1'b0;
    end else begin
      pre_reg    <= pre_wrap ? '0 : pre_reg + 1'b1;
      cnt_reg    <= pre_wrap ? cnt_reg + 1'b1 : cnt_reg;
      expire_reg <= pre_wrap && (&cnt_reg);
    end
  end

  assign count_o    = cnt_reg;
  assign prescale_o = pre_reg;
  assign expire_o   = expire_reg;

endmodule : ccd_watchdog
`default_nettype wire

// ---- rtl/ccd_exec_core.sv ----
// Execution core for watchdog clear, call, invert, zero and decrement instructions.
// Assumes program memory answers PROG_ADDR_O combinationally on INSTR_I in the
// same cycle, one clock per instruction cycle, and that the page latch and
// external file writes come from logic on the same clock.
// Nothing executes while reset is held; the file array itself is never cleared.
//
// The plain strobed port and the register offsets were decided locally.
`timescale 1ns/10ps
`default_nettype none
`include "ccd_consts.svh"

// Summary of operation
// - The watchdog clear instruction returns the watchdog counter to zero.
// - The same instruction also returns the watchdog prescaler to zero.
// - The same instruction sets the expiry and sleep flags, both active low, to one and nothing else.
// - A call pushes the address of the next instruction, the program counter plus one, onto the stack.
// - A call loads its eleven-bit immediate into counter bits 10:0 and page latch bits 4:3 into bits 12:11.
// - A call takes two instruction cycles and changes no status flag.
// - Invert complements the file register and stores it in the accumulator for d=0 or the file for d=1.
// - Zero file writes zero to the addressed file register and sets the zero flag.
// - Zero accumulator writes zero to the accumulator and sets the zero flag.
// - Decrement subtracts one from the file register and stores it per the destination bit.
// - Decrement and skip stores per the destination bit and on a zero result runs a no-op in place of the next instruction.
// - On a nonzero result decrement and skip runs the next instruction normally and never touches a flag.
module ccd_exec_core
  import ccd_pkg::*;
#(
  parameter logic [`DOG_PRE_W-1:0] DOG_PRE_LIMIT = `DOG_PRE_LIMIT
)
(
  input  wire logic                  CLK_I,
  input  wire logic                  RSTN_I,
  input  wire logic [`INSTR_W-1:0]   INSTR_I,
  output logic      [`PC_W-1:0]      PROG_ADDR_O,
  input  wire logic [`PAGE_W-1:0]    PAGE_LATCH_I,
  input  wire logic                  FILE_WE_I,
  input  wire logic [`FADDR_W-1:0]   FILE_WADDR_I,
  input  wire logic [`DATA_W-1:0]    FILE_WDATA_I,
  input  wire logic [`FADDR_W-1:0]   FILE_RADDR_I,
  output logic      [`DATA_W-1:0]    FILE_RDATA_O,
  input  wire logic                  SLEEP_ENTER_I,
  output logic      [`DATA_W-1:0]    ACC_O,
  output logic                       ZERO_FLAG_O,
  output logic                       DOG_EXPIRY_N_O,
  output logic                       SLEEP_N_O,
  output logic      [`PC_W-1:0]      STACK_TOP_O,
  output logic                       STACK_PUSH_O,
  output logic                       DOG_CLEAR_O,
  output logic      [`DOG_CNT_W-1:0] DOG_COUNT_O,
  output logic      [`DOG_PRE_W-1:0] DOG_PRESCALE_O,
  output logic                       FLUSH_O
);

  // Sequencing and architectural state
  core_state_t               state_reg;
  core_state_t               state_next;
  logic [`PC_W-1:0]          pc_reg;
  logic [`PC_W-1:0]          pc_next;
  logic [`DATA_W-1:0]        acc_reg;
  logic                      zero_reg;
  logic                      dog_expiry_flag_n;
  logic                      sleep_flag_n;
  logic [`DATA_W-1:0]        rdata_reg;

  // File register storage
  logic [`DATA_W-1:0]        file_mem [`FILE_DEPTH];

  // Decode results
  op_class_t                 op_class;
  logic [`OP_HI-`OP_LO:0]    op_field;
  logic                      dest_file;
  logic [`FADDR_W-1:0]       faddr;
  logic [`CALL_K_W-1:0]      call_k;
  logic [`DATA_W-1:0]        fval;
  logic [`DATA_W-1:0]        result;
  logic                      result_zero;
  logic                      exec_valid;

  // Side effects of the decoded instruction
  logic                      wr_file;
  logic                      wr_acc;
  logic                      wr_zero;
  logic                      zero_value;
  logic                      watchdog_clear_op;
  logic                      push;
  logic                      dog_expire;

  // Call operands
  logic [`PC_W-1:0]          ret_addr;
  logic [`PAGE_HI-`PAGE_LO:0] page_bits;
  logic [`PC_W-1:0]          stack_top;

  // Instruction fields
  assign op_field  = INSTR_I[`OP_HI:`OP_LO];
  assign dest_file = INSTR_I[`DEST_BIT];
  assign faddr     = INSTR_I[`FADDR_W-1:0];
  assign call_k    = INSTR_I[`CALL_K_W-1:0];

  // A flush cycle ignores whatever word program memory presents
  assign exec_valid = (state_reg == ST_EXEC);

  // Decode; unknown words act as no-ops so stray code cannot corrupt state
  // Calls match on their three-bit prefix ahead of the six-bit opcodes
  always_comb begin
    op_class = OPC_NONE;
    if (!exec_valid) begin
      op_class = OPC_NONE;
    end else if (!RSTN_I) begin
      // Nothing executes under reset, so no instruction file write can slip in at the reset edge
      op_class = OPC_NONE;
    end else if (INSTR_I == `OP_DOG_CLEAR) begin
      op_class = OPC_DOG;
    end else if (INSTR_I[`OP_HI:`CALL_PFX_LO] == `OP_CALL_PFX) begin
      op_class = OPC_CALL;
    end else begin
      case (op_field)
        `OP_INVERT: begin
          op_class = OPC_INVERT;
        end
        `OP_DEC: begin
          op_class = OPC_DEC;
        end
        `OP_DEC_SKIP: begin
          op_class = OPC_DEC_SKIP;
        end
        `OP_ZERO: begin
          op_class = dest_file ? OPC_ZERO_F : OPC_ZERO_A;
        end
        default: begin
          op_class = OPC_NONE;
        end
      endcase
    end
  end

  // Operand read is asynchronous from the file array
  assign fval = file_mem[faddr];

  // Result datapath
  // Zero opcodes still read the operand; the value is simply not used
  always_comb begin
    result = `ZERO_BYTE;
    case (op_class)
      OPC_INVERT: begin
        result = ~fval;
      end
      OPC_DEC, OPC_DEC_SKIP: begin
        result = fval - `ONE_BYTE;
      end
      OPC_ZERO_F, OPC_ZERO_A: begin
        result = `ZERO_BYTE;
      end
      default: begin
        result = `ZERO_BYTE;
      end
    endcase
  end

  assign result_zero = (result == `ZERO_BYTE);

  // Destination and flag steering
  // Decrement and skip stores like decrement but never touches the flag
  always_comb begin
    wr_file    = 1'b0;
    wr_acc     = 1'b0;
    wr_zero    = 1'b0;
    zero_value = 1'b0;
    case (op_class)
      OPC_INVERT, OPC_DEC: begin
        wr_file    = dest_file;
        wr_acc     = !dest_file;
        wr_zero    = 1'b1;
        zero_value = result_zero;
      end
      OPC_DEC_SKIP: begin
        wr_file    = dest_file;
        wr_acc     = !dest_file;
        wr_zero    = 1'b0;
      end
      OPC_ZERO_F: begin
        wr_file    = 1'b1;
        wr_zero    = 1'b1;
        zero_value = 1'b1;
      end
      OPC_ZERO_A: begin
        wr_acc     = 1'b1;
        wr_zero    = 1'b1;
        zero_value = 1'b1;
      end
      default: begin
        wr_file    = 1'b0;
      end
    endcase
  end

  assign watchdog_clear_op = (op_class == OPC_DOG);
  assign push              = (op_class == OPC_CALL);

  // Call operands; the return address wraps at the top of program memory
  assign ret_addr  = pc_reg + `PC_ONE;
  assign page_bits = PAGE_LATCH_I[`PAGE_HI:`PAGE_LO];

  // Next program counter and sequencing state
  // A taken skip jumps straight over the discarded word, so that word is never decoded
  always_comb begin
    pc_next    = pc_reg + `PC_ONE;
    state_next = ST_EXEC;
    case (op_class)
      OPC_CALL: begin
        pc_next    = {page_bits, call_k};
        state_next = ST_FLUSH;
      end
      OPC_DEC_SKIP: begin
        if (result_zero) begin
          pc_next    = pc_reg + `PC_TWO;
          state_next = ST_FLUSH;
        end else begin
          pc_next    = pc_reg + `PC_ONE;
        end
      end
      default: begin
        // A flush cycle holds the counter so the target or skip address runs next
        if (!exec_valid) begin
          pc_next = pc_reg;
        end
      end
    endcase
  end

  // Program counter and state registers
  // Reset parks the core at address zero with no flush pending
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      pc_reg    <= `PC_RESET;
      state_reg <= ST_EXEC;
    end else begin
      pc_reg    <= pc_next;
      state_reg <= state_next;
    end
  end

  // Accumulator
  // Written only by the clear, invert and decrement forms that target it
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      acc_reg <= `ZERO_BYTE;
    end else if (wr_acc) begin
      acc_reg <= result;
    end
  end

  // File writes: the instruction owns the single write port, external loads yield
  // A dropped external load is lost, not retried, so the writer must avoid such cycles
  always_ff @(posedge CLK_I) begin
    if (wr_file) begin
      file_mem[faddr] <= result;
    end else if (FILE_WE_I) begin
      file_mem[FILE_WADDR_I] <= FILE_WDATA_I;
    end
  end

  // Zero flag; calls, skips and watchdog clears leave it untouched
  // Carries live outside this block, so only the zero flag is kept here
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      zero_reg <= 1'b0;
    end else if (wr_zero) begin
      zero_reg <= zero_value;
    end
  end

  // Expiry flag: set by the clear instruction, cleared when the watchdog runs out
  // An expiry registered the cycle before can meet a clear; the clear then wins
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      dog_expiry_flag_n <= 1'b1;
    end else if (watchdog_clear_op) begin
      dog_expiry_flag_n <= 1'b1;
    end else if (dog_expire) begin
      dog_expiry_flag_n <= 1'b0;
    end
  end

  // Sleep flag: the set by the clear instruction wins over a same-cycle sleep entry
  // Sleep entry comes as a one-cycle pulse from power logic on this clock
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      sleep_flag_n <= 1'b1;
    end else if (watchdog_clear_op) begin
      sleep_flag_n <= 1'b1;
    end else if (SLEEP_ENTER_I) begin
      sleep_flag_n <= 1'b0;
    end
  end

  // Observation port, registered so it shows the file one cycle after the address
  // It shows the value from before any write at the same edge
  always_ff @(posedge CLK_I) begin
    if (!RSTN_I) begin
      rdata_reg <= `ZERO_BYTE;
    end else begin
      rdata_reg <= file_mem[FILE_RADDR_I];
    end
  end

  // Return stack takes the address after the call
  // A deep nest overwrites the oldest entry without warning
  ccd_return_stack u_stack (
    .clk_i  (CLK_I),
    .rstn_i (RSTN_I),
    .push_i (push),
    .data_i (ret_addr),
    .top_o  (stack_top)
  );

  // Watchdog counter and prescaler share the one clear strobe
  // Counting goes on through flush cycles, one step per instruction cycle
  ccd_watchdog #(
    .PRE_LIMIT (DOG_PRE_LIMIT)
  ) u_watchdog (
    .clk_i      (CLK_I),
    .rstn_i     (RSTN_I),
    .clear_i    (watchdog_clear_op),
    .count_o    (DOG_COUNT_O),
    .prescale_o (DOG_PRESCALE_O),
    .expire_o   (dog_expire)
  );

  // Output drive: data and flags straight from flip-flops
  assign PROG_ADDR_O    = pc_reg;
  assign FILE_RDATA_O   = rdata_reg;
  assign ACC_O          = acc_reg;
  assign ZERO_FLAG_O    = zero_reg;
  assign DOG_EXPIRY_N_O = dog_expiry_flag_n;
  assign SLEEP_N_O      = sleep_flag_n;
  assign STACK_TOP_O    = stack_top;

  // Push and clear strobes come from the decode, so they stand only in the execute cycle
  assign STACK_PUSH_O   = push;              // Combinational strobe
  assign DOG_CLEAR_O    = watchdog_clear_op; // Combinational strobe
  assign FLUSH_O        = !exec_valid;

endmodule : ccd_exec_core
`default_nettype wire

// ---- bench/ccd_prog_mem.sv ----
// Program memory model feeding instruction words to the core.
// Assumes the bench loads every word before reset is released.
`timescale 1ns/10ps
`default_nettype none

module ccd_prog_mem (
  input  wire logic [12:0] addr_i,
  output logic      [13:0] instr_o
);
  logic [13:0] mem [8192];

  // Read without a clock, as the core fetches and executes in one cycle
  assign instr_o = mem[addr_i];
endmodule : ccd_prog_mem

`default_nettype wire

// ---- bench/ccd_exec_core_props.sv ----
// Checker for the execution core, bound to its top module.
// Assumes one instruction clock and the synchronous active-low reset.
`timescale 1ns/10ps
`default_nettype none

module ccd_exec_core_props #(
  parameter logic [7:0] DOG_PRE_LIMIT = 8'h80
) (
  input wire logic        CLK_I,
  input wire logic        RSTN_I,
  input wire logic [13:0] INSTR_I,
  input wire logic [12:0] PROG_ADDR_O,
  input wire logic [4:0]  PAGE_LATCH_I,
  input wire logic [7:0]  ACC_O,
  input wire logic        ZERO_FLAG_O,
  input wire logic        DOG_EXPIRY_N_O,
  input wire logic        SLEEP_N_O,
  input wire logic [12:0] STACK_TOP_O,
  input wire logic        STACK_PUSH_O,
  input wire logic        DOG_CLEAR_O,
  input wire logic [7:0]  DOG_COUNT_O,
  input wire logic [7:0]  DOG_PRESCALE_O,
  input wire logic        FLUSH_O
);
  default clocking @(posedge CLK_I); endclocking
  default disable iff (!RSTN_I);
  logic [5:0] op;
  logic       ex;

  // Opcode field, and whether this cycle executes at all
  assign op = INSTR_I[13:8];
  assign ex = !FLUSH_O;

  // A call is followed by one discarded cycle holding the target
  sequence s_call_tail;
    FLUSH_O && $stable(ZERO_FLAG_O) ##1 !FLUSH_O && $stable(PROG_ADDR_O);
  endsequence

  a_dog_count_zero: assert property (DOG_CLEAR_O |=> DOG_COUNT_O == 8'h00)
    else $error("watchdog count not cleared");
  a_dog_pre_zero: assert property (DOG_CLEAR_O |=> DOG_PRESCALE_O == 8'h00)
    else $error("prescaler not cleared");
  a_dog_flags_set: assert property (DOG_CLEAR_O |=> DOG_EXPIRY_N_O && SLEEP_N_O)
    else $error("expiry or sleep flag not set");
  a_call_ret_addr: assert property (
    STACK_PUSH_O |=> STACK_TOP_O == $past(PROG_ADDR_O) + 13'h0001)
    else $error("wrong return address");
  a_call_target: assert property (
    STACK_PUSH_O |=> PROG_ADDR_O == {$past(PAGE_LATCH_I[4:3]), $past(INSTR_I[10:0])})
    else $error("wrong call target");
  a_call_two_cyc: assert property (STACK_PUSH_O |=> s_call_tail)
    else $error("call not two cycles");
  a_zero_flag_set: assert property (ex && op == 6'h14 |=> ZERO_FLAG_O)
    else $error("zero flag not set by clear");
  a_zero_acc: assert property (ex && op == 6'h14 && !INSTR_I[7] |=> ACC_O == 8'h00)
    else $error("accumulator not cleared");
  a_skip_pc_step: assert property (
    ex && op == 6'h13 |=> PROG_ADDR_O == $past(PROG_ADDR_O) + (FLUSH_O ? 13'h0002 : 13'h0001))
    else $error("wrong address after skip");
  a_skip_on_zero: assert property (
    ex && op == 6'h13 && !INSTR_I[7] |=> FLUSH_O == (ACC_O == 8'h00))
    else $error("skip disagrees with result");
  a_skip_keeps_flag: assert property (ex && op == 6'h13 |=> $stable(ZERO_FLAG_O))
    else $error("skip changed zero flag");
  a_result_zero: assert property (
    ex && (op == 6'h11 || op == 6'h12) && !INSTR_I[7] |=> ZERO_FLAG_O == (ACC_O == 8'h00))
    else $error("zero flag disagrees with result");
  a_flush_quiet: assert property (FLUSH_O |-> !STACK_PUSH_O && !DOG_CLEAR_O)
    else $error("discarded cycle executed");
endmodule : ccd_exec_core_props

bind ccd_exec_core ccd_exec_core_props #(.DOG_PRE_LIMIT(DOG_PRE_LIMIT)) u_ccd_exec_core_props (
  .CLK_I(CLK_I), .RSTN_I(RSTN_I), .INSTR_I(INSTR_I), .PROG_ADDR_O(PROG_ADDR_O),
  .PAGE_LATCH_I(PAGE_LATCH_I), .ACC_O(ACC_O), .ZERO_FLAG_O(ZERO_FLAG_O),
  .DOG_EXPIRY_N_O(DOG_EXPIRY_N_O), .SLEEP_N_O(SLEEP_N_O), .STACK_TOP_O(STACK_TOP_O),
  .STACK_PUSH_O(STACK_PUSH_O), .DOG_CLEAR_O(DOG_CLEAR_O), .DOG_COUNT_O(DOG_COUNT_O),
  .DOG_PRESCALE_O(DOG_PRESCALE_O), .FLUSH_O(FLUSH_O));

`default_nettype wire

// ---- bench/test_ccd_exec_core.sv ----
// Bench for the execution core: random program, compared each cycle with a model.
// Assumes the program memory model and the checker are compiled first.
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end

module test_ccd_exec_core;
  localparam int PL = 4;
  logic        clk = 1'b0;
  logic        rstn = 1'b0;
  logic        fwe = 1'b0;
  logic        sle = 1'b0;
  logic [4:0]  pl = 5'h00;
  logic [6:0]  fwa = 7'h00;
  logic [6:0]  fra = 7'h00;
  logic [7:0]  fwd = 8'h00;
  logic [31:0] lf = 32'hf59c69ab;
  logic [5:0]  opt [8] = '{6'h00, 6'h00, 6'h11, 6'h12, 6'h13, 6'h14, 6'h00, 6'h13};
  wire  [13:0] ins;
  wire  [12:0] pa, top;
  wire  [7:0]  rdo, acc, cnt, pre;
  wire         zf, dxn, sln, push, dclr, fl;
  int          mismatches = 0;
  int          n_checks = 0;
  int          cyc = 0;
  logic [12:0] m_pc, m_tos, np;
  logic [7:0]  m_acc, m_cnt, m_pre, m_rd, v;
  logic [7:0]  m_file [128];
  logic        m_z, m_dx, m_sl, m_fl, m_exp, nf, wf, ck, wrap;

  // Prescaler shortened so the watchdog moves visibly
  ccd_exec_core #(.DOG_PRE_LIMIT(8'h04)) u_ccd_exec_core (
    .CLK_I(clk), .RSTN_I(rstn), .INSTR_I(ins), .PROG_ADDR_O(pa), .PAGE_LATCH_I(pl),
    .FILE_WE_I(fwe), .FILE_WADDR_I(fwa), .FILE_WDATA_I(fwd), .FILE_RADDR_I(fra),
    .FILE_RDATA_O(rdo), .SLEEP_ENTER_I(sle), .ACC_O(acc), .ZERO_FLAG_O(zf),
    .DOG_EXPIRY_N_O(dxn), .SLEEP_N_O(sln), .STACK_TOP_O(top), .STACK_PUSH_O(push),
    .DOG_CLEAR_O(dclr), .DOG_COUNT_O(cnt), .DOG_PRESCALE_O(pre), .FLUSH_O(fl));
  ccd_prog_mem u_ccd_prog_mem (.addr_i(pa), .instr_o(ins));

  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return x[0] ? (x >> 1) ^ 32'h80200003 : x >> 1;
  endfunction : lfsr_next

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : end_of_test

  always #5 clk = ~clk;

  // Hang guard, well above the planned run of about 3180 cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 6000) begin
      mismatches++;
      end_of_test();
    end
  end

  // Reference model, stepped from the values seen just before each edge
  always @(posedge clk) begin
    v = m_file[ins[6:0]];
    ck = rstn && !m_fl && u_ccd_prog_mem.mem[m_pc] == 14'h0015;
    if (rstn) begin
      `CHK("push", !m_fl && u_ccd_prog_mem.mem[m_pc][13:11] == 3'h4, push)
      `CHK("dog clear", ck, dclr)
    end
    if (!rstn) begin
      {m_pc, m_tos, m_acc, m_cnt, m_pre, m_rd, m_z, m_fl, m_exp} = '0;
      {m_dx, m_sl} = 2'b11;
    end else begin
      m_rd = m_file[fra];
      np = m_pc + 13'h0001;
      {nf, wf} = 2'b00;
      if (m_fl) np = m_pc;
      else begin
        if (ins[13:11] == 3'h4) begin
          m_tos = np;
          np = {pl[4:3], ins[10:0]};
          nf = 1'b1;
        end
        case (ins[13:8])
          6'h11: v = ~v;
          6'h12, 6'h13: v = v - 8'h01;
          6'h14: v = 8'h00;
          default: ;
        endcase
        if (ins[13:8] inside {[6'h11:6'h14]}) begin
          if (ins[13:8] != 6'h13) m_z = (v == 8'h00);
          if (ins[13:8] == 6'h13 && v == 8'h00) begin
            np = m_pc + 13'h0002;
            nf = 1'b1;
          end
          if (ins[7]) begin
            m_file[ins[6:0]] = v;
            wf = 1'b1;
          end else m_acc = v;
        end
      end
      {m_pc, m_fl} = {np, nf};
      if (fwe && !wf) m_file[fwa] = fwd;
      wrap = (m_pre == 8'(PL - 1));
      if (m_exp) m_dx = 1'b0;
      m_exp = wrap && m_cnt == 8'hff;
      m_pre = wrap ? 8'h00 : m_pre + 8'h01;
      if (wrap) m_cnt++;
      if (sle) m_sl = 1'b0;
      if (ck) {m_cnt, m_pre, m_dx, m_sl, m_exp} = {16'h0000, 3'b110};
    end
  end

  // Compare at the falling edge, where every output has settled
  always @(negedge clk) begin
    `CHK("pc", m_pc, pa)
    `CHK("acc", m_acc, acc)
    `CHK("zero", m_z, zf)
    `CHK("expiry", m_dx, dxn)
    `CHK("sleep", m_sl, sln)
    `CHK("stack", m_tos, top)
    `CHK("count", m_cnt, cnt)
    `CHK("prescale", m_pre, pre)
    `CHK("flush", m_fl, fl)
    `CHK("file", m_rd, rdo)
  end

  // Program: no-ops while the file fills and the watchdog runs out, then random work on eight bytes
  initial begin
    for (int a = 0; a < 8192; a++) begin
      lf = lfsr_next(lf);
      u_ccd_prog_mem.mem[a] = {opt[lf[2:0]], lf[9], 4'h0, lf[12:10]};
      if (lf[2:0] == 3'h0) u_ccd_prog_mem.mem[a] = 14'h0015;
      if (lf[2:0] == 3'h1) u_ccd_prog_mem.mem[a] = {3'h4, 1'b1, lf[17:8]}; // Targets 1024 and up, near the end of the prologue
      if (a < 1040) u_ccd_prog_mem.mem[a] = 14'h0000;
    end
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    for (int i = 0; i < 128; i++) begin
      fwe <= 1'b1;
      fwa <= 7'(i);
      fwd <= 8'(i % 4);
      fra <= 7'(i);
      @(posedge clk);
    end
    $display("test file fill done");
    repeat (3000) begin
      lf = lfsr_next(lf);
      fwe <= lf[3] & lf[4];
      fwa <= lf[10:4];
      fwd <= lf[11] ? lf[23:16] : {6'h00, lf[13:12]};
      fra <= lf[30:24];
      pl <= lf[20:16];
      sle <= lf[5] & lf[6] & lf[7];
      @(posedge clk);
    end
    $display("test random program done");
    // Reset mid-run: state returns to its reset values, the file array keeps its contents
    fwe <= 1'b0;
    sle <= 1'b0;
    rstn <= 1'b0;
    repeat (3) @(posedge clk);
    rstn <= 1'b1;
    repeat (40) @(posedge clk);
    $display("test mid-run reset done");
    end_of_test();
  end
endmodule : test_ccd_exec_core

`default_nettype wire
